// File: src/pmr_pkg.sv
// Package for the power mode and reset control block.
// Assumes a single 10 MHz system clock and a synchronous active-high reset.
package pmr_pkg;

    // ****************************************************************
    // Register map and field layout.
    // ****************************************************************
    localparam logic [7:0] PMR_POWER_CONTROL_ADDR = 8'h87;
    localparam logic [7:0] PMR_POWER_CONTROL_RESET = 8'h00;
    localparam int PMR_IDLE_BIT = 0;
    localparam int PMR_STOP_BIT = 1;
    localparam int PMR_FLAGS_LSB = 2;
    localparam int PMR_FLAGS_MSB = 7;
    localparam logic [5:0] PMR_FLAGS_RESET = 6'h00;

    // ****************************************************************
    // Reset values seen by the rest of the device.
    // ****************************************************************
    localparam logic [15:0] PMR_RESET_VECTOR = 16'h0000;
    localparam logic [7:0] PMR_PORT_LATCH_RESET = 8'hFF;
    localparam logic [3:0] PMR_WATCHDOG_DIVIDE = 4'hC;

    // ****************************************************************
    // Timing.
    // ****************************************************************
    localparam int PMR_CLOCK_HZ = 10_000_000;
    localparam int PMR_MISSING_CLOCK_US = 100;
    // Longest time rounds down: 100 us at 10 MHz gives 1000 cycles.
    localparam int PMR_MISSING_CLOCK_CYCLES = (PMR_MISSING_CLOCK_US * (PMR_CLOCK_HZ / 1_000_000));
    // Cycles reset is stretched internally after the source goes away.
    localparam int PMR_RESET_STRETCH_CYCLES = 4;

    // ****************************************************************
    // Power modes.
    // ****************************************************************
    typedef enum logic [1:0] {
        PMR_MODE_RUN,
        PMR_MODE_IDLE,
        PMR_MODE_STOP
    } pmr_mode_type;

endpackage

// File: src/pmr_sync.sv
// Two flip-flop synchroniser for a single level from outside the clock domain.
// Assumes the input may change at any time relative to clock_i.
`timescale 1ns/1ps
module pmr_sync
    import pmr_pkg::*;
(
    // Clock and reset.
    input wire logic clock_i,
    input wire logic rst_i,
    // Level in and out.
    input wire logic async_i,
    input wire logic reset_value_i,
    output logic sync_o
);

    logic meta_reg;
    logic sync_reg;

    // The first stage feeds only the second stage.
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end
        else
        begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
        end
    end

    assign sync_o = sync_reg ^ reset_value_i;

endmodule

// File: src/pmr_missing_clock.sv
// Missing clock watch counter: raises a timeout after a long silent stretch.
// Assumes the tick input changes level while the watched clock runs.
`timescale 1ns/1ps
module pmr_missing_clock
    import pmr_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = PMR_MISSING_CLOCK_CYCLES
)
(
    // Clock and reset.
    input wire logic clock_i,
    input wire logic rst_i,
    // Control.
    input wire logic enable_i,
    input wire logic tick_i,
    // Result.
    output logic timeout_o
);

    logic [15:0] count_reg;
    logic timeout_reg;
    logic tick_last_reg;
    logic tick_seen;

    // Any change of the tick level counts as activity, so a watched clock
    // that halts high is caught just like one that halts low.
    always_ff @(posedge clock_i)
    begin
        tick_last_reg <= tick_i;
    end

    assign tick_seen = tick_i ^ tick_last_reg;

    // Count cycles without a tick; the detector keeps counting in Stop.
    always_ff @(posedge clock_i)
    begin
        if (rst_i || !enable_i || tick_seen)
        begin
            count_reg <= 16'h0000;
            timeout_reg <= 1'b0;
        end
        else if (count_reg == 16'(TIMEOUT_CYCLES - 1))
        begin
            timeout_reg <= 1'b1;
        end
        else
        begin
            count_reg <= count_reg + 16'h0001;
        end
    end

    assign timeout_o = timeout_reg;

endmodule

// File: src/pmr_power_reset.sv
// Power mode and reset control: Idle and Stop selection, reset entry and exit.
// Assumes the CPU presents register writes on a simple internal port and
// reports when the current instruction completes.
//
// Notes on behaviour
// - Idle entered after writing instruction completes.
// - Idle gates only the CPU clock.
// - Enabled interrupt clears idle, restarts CPU.
// - Reset ends Idle, restarts at zero.
// - Watchdog expiry in Idle resets device.
// - Stop halts oscillator, CPU, digital peripherals.
// - Only reset leaves Stop; interrupts ignored.
// - Missing clock detector resets during Stop.
// - Stop and idle bits read zero.
// - Upper six bits are plain flags.
// - Reset halts CPU, disables interrupts, timers.
// - Reset keeps data memory, reinitialises stack.
// - Port latches all ones, open drain, pull-ups.
// - Power resets drive reset pin low.
// - Reset exit selects internal oscillator, vector zero.
// - Watchdog enabled at clock divided by twelve.
// - Power-on flag set only by power-on.
`timescale 1ns/1ps
module pmr_power_reset
    import pmr_pkg::*;
#(
    parameter int MISSING_CLOCK_CYCLES = PMR_MISSING_CLOCK_CYCLES,
    parameter int STRETCH_CYCLES = PMR_RESET_STRETCH_CYCLES
)
(
    // Clock and reset.
    input wire logic clock_i,
    input wire logic rst_i,
    // Register port from the CPU.
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // CPU handshake.
    input wire logic instr_done_i,
    input wire logic irq_pending_i,
    // Reset sources (from pins or other domains).
    input wire logic power_on_i,
    input wire logic supply_low_i,
    input wire logic ext_reset_n_i,
    input wire logic watchdog_expired_i,
    input wire logic software_reset_i,
    // Missing clock detector control.
    input wire logic missing_clock_enable_i,
    input wire logic osc_tick_i,
    // Clock gating outputs.
    output logic cpu_clock_en_o,
    output logic periph_clock_en_o,
    output logic int_osc_en_o,
    output logic int_osc_select_o,
    // Reset outputs.
    output logic core_reset_o,
    output logic fetch_restart_o,
    output logic [15:0] restart_vector_o,
    output logic stack_reinit_o,
    output logic irq_disable_o,
    output logic timers_disable_o,
    // Port state during reset.
    output logic [7:0] port_latch_o,
    output logic port_open_drain_o,
    output logic weak_pullup_en_o,
    // Reset pin, open drain.
    output logic reset_pin_o,
    output logic reset_pin_oe_o,
    // Watchdog setup and status.
    output logic watchdog_enable_o,
    output logic [3:0] watchdog_divide_o,
    output logic power_on_flag_o,
    output logic [1:0] mode_o
);

    // ****************************************************************
    // Input synchronisers.
    // ****************************************************************
    logic por_sync;
    logic supply_low_sync;
    logic ext_reset_sync;
    logic osc_tick_sync;
    logic missing_timeout;

    pmr_sync u_sync_por (
        .clock_i(clock_i),
        .rst_i(1'b0),
        .async_i(power_on_i),
        .reset_value_i(1'b0),
        .sync_o(por_sync)
    );

    pmr_sync u_sync_supply (
        .clock_i(clock_i),
        .rst_i(1'b0),
        .async_i(supply_low_i),
        .reset_value_i(1'b0),
        .sync_o(supply_low_sync)
    );

    // The pin is active low; the inverting output makes it active high.
    pmr_sync u_sync_ext (
        .clock_i(clock_i),
        .rst_i(1'b0),
        .async_i(ext_reset_n_i),
        .reset_value_i(1'b1),
        .sync_o(ext_reset_sync)
    );

    pmr_sync u_sync_tick (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .async_i(osc_tick_i),
        .reset_value_i(1'b0),
        .sync_o(osc_tick_sync)
    );

    // ****************************************************************
    // Reset source combination.
    // ****************************************************************
    logic power_reset;
    logic any_reset;
    logic [3:0] stretch_reg;
    logic in_reset_reg;
    logic power_cause_reg;
    logic por_cause_reg;

    assign power_reset = por_sync || supply_low_sync;
    // Watchdog and missing clock are internal sources that end Idle or Stop.
    assign any_reset = rst_i || power_reset || ext_reset_sync || watchdog_expired_i
        || software_reset_i || missing_timeout;

    // Hold the reset state a few cycles past the last source so that
    // every consumer sees at least one clean reset cycle.
    always_ff @(posedge clock_i)
    begin
        if (any_reset)
        begin
            stretch_reg <= 4'(STRETCH_CYCLES);
            in_reset_reg <= 1'b1;
        end
        else if (stretch_reg != 4'h0)
        begin
            stretch_reg <= stretch_reg - 4'h1;
        end
        else
        begin
            in_reset_reg <= 1'b0;
        end
    end

    // Remember which kind of source caused the reset.
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            power_cause_reg <= 1'b0;
            por_cause_reg <= 1'b1;
        end
        else if (any_reset)
        begin
            power_cause_reg <= power_reset;
            por_cause_reg <= por_sync;
        end
    end

    // ****************************************************************
    // Missing clock detector, active in every mode including Stop.
    // ****************************************************************
    pmr_missing_clock #(
        .TIMEOUT_CYCLES(MISSING_CLOCK_CYCLES)
    ) u_missing_clock (
        .clock_i(clock_i),
        .rst_i(in_reset_reg),
        .enable_i(missing_clock_enable_i),
        .tick_i(osc_tick_sync),
        .timeout_o(missing_timeout)
    );

    // ****************************************************************
    // Power control register.
    // ****************************************************************
    logic [5:0] flags_reg;
    logic write_hit;
    logic idle_req;
    logic stop_req;
    logic idle_pending_reg;
    logic stop_pending_reg;

    assign write_hit = reg_write_i && (reg_addr_i == PMR_POWER_CONTROL_ADDR);
    assign idle_req = write_hit && reg_wdata_i[PMR_IDLE_BIT];
    assign stop_req = write_hit && reg_wdata_i[PMR_STOP_BIT];

    // The flags only store software data and drive nothing.
    always_ff @(posedge clock_i)
    begin
        if (in_reset_reg)
        begin
            flags_reg <= PMR_FLAGS_RESET;
        end
        else if (write_hit)
        begin
            flags_reg <= reg_wdata_i[PMR_FLAGS_MSB:PMR_FLAGS_LSB];
        end
    end

    // Read data: mode bits always read zero.
    always_ff @(posedge clock_i)
    begin
        if (in_reset_reg)
        begin
            reg_rdata_o <= PMR_POWER_CONTROL_RESET;
        end
        else if (reg_read_i && reg_addr_i == PMR_POWER_CONTROL_ADDR)
        begin
            reg_rdata_o <= {flags_reg, 2'b00};
        end
        else
        begin
            reg_rdata_o <= 8'h00;
        end
    end

    // ****************************************************************
    // Mode state machine.
    // ****************************************************************
    pmr_mode_type mode_reg;
    pmr_mode_type mode_next;

    // Requests wait until the writing instruction has fully completed.
    always_ff @(posedge clock_i)
    begin
        if (in_reset_reg)
        begin
            idle_pending_reg <= 1'b0;
            stop_pending_reg <= 1'b0;
        end
        else if (instr_done_i)
        begin
            idle_pending_reg <= 1'b0;
            stop_pending_reg <= 1'b0;
        end
        else
        begin
            idle_pending_reg <= idle_pending_reg || idle_req;
            stop_pending_reg <= stop_pending_reg || stop_req;
        end
    end

    always_comb
    begin
        mode_next = mode_reg;
        case (mode_reg)
            PMR_MODE_RUN:
            begin
                if (instr_done_i && (stop_pending_reg || stop_req))
                begin
                    mode_next = PMR_MODE_STOP;
                end
                else if (instr_done_i && (idle_pending_reg || idle_req))
                begin
                    mode_next = PMR_MODE_IDLE;
                end
            end
            PMR_MODE_IDLE:
            begin
                if (irq_pending_i)
                begin
                    mode_next = PMR_MODE_RUN;
                end
            end
            PMR_MODE_STOP:
            begin
                mode_next = PMR_MODE_STOP;
            end
            default:
            begin
                mode_next = PMR_MODE_RUN;
            end
        endcase
    end

    // Any reset returns to Run; Stop ends only here, Idle here or by interrupt.
    always_ff @(posedge clock_i)
    begin
        if (in_reset_reg)
        begin
            mode_reg <= PMR_MODE_RUN;
        end
        else
        begin
            mode_reg <= mode_next;
        end
    end

    // ****************************************************************
    // Clock enables. Idle gates only the CPU; registers keep their data
    // because nothing here clears them outside reset.
    // ****************************************************************
    always_ff @(posedge clock_i)
    begin
        if (in_reset_reg)
        begin
            cpu_clock_en_o <= 1'b0;
            periph_clock_en_o <= 1'b1;
            int_osc_en_o <= 1'b1;
            int_osc_select_o <= 1'b1;
        end
        else
        begin
            cpu_clock_en_o <= (mode_next == PMR_MODE_RUN);
            periph_clock_en_o <= (mode_next != PMR_MODE_STOP);
            int_osc_en_o <= (mode_next != PMR_MODE_STOP);
            int_osc_select_o <= int_osc_select_o;
        end
    end

    // ****************************************************************
    // Reset outputs to the core and ports.
    // ****************************************************************
    always_ff @(posedge clock_i)
    begin
        core_reset_o <= in_reset_reg;
        irq_disable_o <= in_reset_reg;
        timers_disable_o <= in_reset_reg;
        // Only the stack pointer is reset; data memory has no reset path.
        stack_reinit_o <= in_reset_reg;
        // One pulse as reset ends tells the CPU to fetch from the vector.
        fetch_restart_o <= in_reset_reg && !any_reset && stretch_reg == 4'h0;
        restart_vector_o <= PMR_RESET_VECTOR;
        port_latch_o <= PMR_PORT_LATCH_RESET;
        port_open_drain_o <= in_reset_reg || port_open_drain_o;
        weak_pullup_en_o <= 1'b1;
        watchdog_divide_o <= PMR_WATCHDOG_DIVIDE;
    end

    // Watchdog is enabled on reset exit; software may later disable it
    // through its own register, which lives outside this block.
    always_ff @(posedge clock_i)
    begin
        if (in_reset_reg)
        begin
            watchdog_enable_o <= 1'b1;
        end
    end

    // The pin is driven low only for power-on and supply resets.
    always_ff @(posedge clock_i)
    begin
        reset_pin_o <= 1'b0;
        reset_pin_oe_o <= in_reset_reg && (power_reset || power_cause_reg);
    end

    // Power-on flag shows the cause of the most recent reset.
    always_ff @(posedge clock_i)
    begin
        power_on_flag_o <= por_cause_reg;
        mode_o <= mode_reg;
    end

endmodule

// File: test/pmr_power_reset_sva.sv
// Checker for the power mode and reset control block.
// Assumes it is bound to the block and sees only its ports.
`timescale 1ns/1ps
module pmr_power_reset_sva
    import pmr_pkg::*;
(
    // Clock and reset.
    input wire logic clock_i,
    input wire logic rst_i,
    // Register port, CPU handshake and two reset sources.
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic instr_done_i,
    input wire logic irq_pending_i,
    input wire logic power_on_i,
    input wire logic watchdog_expired_i,
    // Block outputs.
    input wire logic cpu_clock_en_o,
    input wire logic periph_clock_en_o,
    input wire logic int_osc_en_o,
    input wire logic core_reset_o,
    input wire logic fetch_restart_o,
    input wire logic irq_disable_o,
    input wire logic timers_disable_o,
    input wire logic [7:0] port_latch_o,
    input wire logic reset_pin_o,
    input wire logic reset_pin_oe_o,
    input wire logic [3:0] watchdog_divide_o,
    input wire logic [1:0] mode_o
);
    // ****
    // Shared clocking and the steps that the properties build on.
    // ****
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    sequence idle_write_s;
        reg_write_i && reg_addr_i == PMR_POWER_CONTROL_ADDR && reg_wdata_i[1:0] == 2'b01;
    endsequence
    sequence quiet_s;
        !core_reset_o && !irq_pending_i && !watchdog_expired_i;
    endsequence
    sequence flag_write_s;
        reg_write_i && reg_addr_i == PMR_POWER_CONTROL_ADDR && !core_reset_o;
    endsequence
    // Idle must wait for the writing instruction to finish.
    idle_wait_a: assert property (idle_write_s ##0 (mode_o == PMR_MODE_RUN && !instr_done_i)
        |=> mode_o == PMR_MODE_RUN) else $error("idle entered before completion");
    // The mode output trails the clock enables by one edge.
    idle_entry_a: assert property (idle_write_s ##0 quiet_s ##0 mode_o == PMR_MODE_RUN
        ##1 (instr_done_i && !reg_write_i) ##0 quiet_s |=> ##1 mode_o == PMR_MODE_IDLE)
        else $error("idle not entered");
    idle_wake_a: assert property (mode_o == PMR_MODE_IDLE && irq_pending_i && !core_reset_o
        |=> cpu_clock_en_o ##1 mode_o == PMR_MODE_RUN) else $error("interrupt did not wake");
    stop_halt_a: assert property (mode_o == PMR_MODE_STOP && !core_reset_o
        |-> !cpu_clock_en_o && !periph_clock_en_o && !int_osc_en_o) else $error("stop runs");
    // Stop is left only by way of a reset.
    stop_hold_a: assert property (mode_o == PMR_MODE_STOP && !core_reset_o
        |=> (mode_o == PMR_MODE_STOP) or (##[0:2] core_reset_o)) else $error("stop left");
    flag_read_a: assert property (flag_write_s ##1 !reg_write_i
        ##1 (reg_read_i && !reg_write_i && reg_addr_i == PMR_POWER_CONTROL_ADDR && !core_reset_o)
        |=> reg_rdata_o[7:2] == $past(reg_wdata_i[7:2], 3)) else $error("flags lost");
    read_zero_a: assert property (reg_read_i |=> reg_rdata_o[1:0] == 2'b00
        && (reg_rdata_o == 8'h00 || $past(reg_addr_i) == PMR_POWER_CONTROL_ADDR))
        else $error("select bits read back");
    reset_state_a: assert property (core_reset_o |-> irq_disable_o && timers_disable_o
        && port_latch_o == PMR_PORT_LATCH_RESET) else $error("reset state wrong");
    restart_pulse_a: assert property (fetch_restart_o |-> watchdog_divide_o == 4'hC
        ##1 (!fetch_restart_o && !core_reset_o)) else $error("restart pulse wrong");
    pin_drive_a: assert property ($rose(power_on_i)
        |-> ##[1:6] (reset_pin_oe_o && !reset_pin_o)) else $error("reset pin not driven");
endmodule

// File: test/pmr_cpu_model.sv
// Model of the CPU core and the watched oscillator beside the block.
// Assumes each register write is one multi-byte instruction from the bench.
`timescale 1ns/1ps
module pmr_cpu_model (
    // Clock and reset.
    input wire logic clock_i,
    input wire logic rst_i,
    // Observed from the block.
    input wire logic reg_write_i,
    input wire logic int_osc_en_o,
    // Driven into the block.
    output logic instr_done_o,
    output logic osc_tick_o
);
    // The writing instruction completes one edge after its write strobe.
    always_ff @(posedge clock_i)
    begin
        instr_done_o <= reg_write_i && !rst_i;
    end
    // A halted oscillator holds its level, so the watch counter sees silence.
    always_ff @(posedge clock_i)
    begin
        osc_tick_o <= rst_i ? 1'b0 : (int_osc_en_o ? ~osc_tick_o : osc_tick_o);
    end
endmodule

// File: test/pmr_power_reset_test.sv
// Testbench for the power mode and reset control block.
// Assumes the CPU model beside it completes every write instruction.
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin err_total++; \
    $display("mismatch %s expected %h seen %h", n, e, s); end end
module pmr_power_reset_test import pmr_pkg::*; ;
    logic clock_i = 0, rst_i = 1, reg_write_i = 0, reg_read_i = 0, instr_done_i;
    logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, port_latch_o, d;
    logic irq_pending_i = 0, power_on_i = 0, supply_low_i = 0, ext_reset_n_i = 1;
    logic watchdog_expired_i = 0, software_reset_i = 0, missing_clock_enable_i = 0, osc_tick_i;
    logic cpu_clock_en_o, periph_clock_en_o, int_osc_en_o, int_osc_select_o, core_reset_o;
    logic fetch_restart_o, stack_reinit_o, irq_disable_o, timers_disable_o, port_open_drain_o;
    logic weak_pullup_en_o, reset_pin_o, reset_pin_oe_o, watchdog_enable_o, power_on_flag_o;
    logic [15:0] restart_vector_o;
    logic [3:0] watchdog_divide_o;
    logic [1:0] mode_o;
    int err_total = 0, comparisons = 0;
    // ****
    // Block, CPU model and clock. The watch count is shortened to keep runs brief.
    // ****
    pmr_power_reset #(.MISSING_CLOCK_CYCLES(20)) dut_u (.clock_i, .rst_i, .reg_write_i,
        .reg_read_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .instr_done_i, .irq_pending_i,
        .power_on_i, .supply_low_i, .ext_reset_n_i, .watchdog_expired_i, .software_reset_i,
        .missing_clock_enable_i, .osc_tick_i, .cpu_clock_en_o, .periph_clock_en_o,
        .int_osc_en_o, .int_osc_select_o, .core_reset_o, .fetch_restart_o, .restart_vector_o,
        .stack_reinit_o, .irq_disable_o, .timers_disable_o, .port_latch_o, .port_open_drain_o,
        .weak_pullup_en_o, .reset_pin_o, .reset_pin_oe_o, .watchdog_enable_o,
        .watchdog_divide_o, .power_on_flag_o, .mode_o);
    pmr_cpu_model cpu_u (.clock_i, .rst_i, .reg_write_i, .int_osc_en_o,
        .instr_done_o(instr_done_i), .osc_tick_o(osc_tick_i));
    initial forever #50 clock_i = ~clock_i;
    task automatic tick(int n);
        repeat (n) @(posedge clock_i);
    endtask
    // Register cycles leave an idle edge after them so strobes never collide.
    task automatic wr(logic [7:0] a, logic [7:0] v);
        reg_write_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= v;
        tick(1);
        reg_write_i <= 1'b0;
        tick(1);
    endtask
    task automatic rd(logic [7:0] a);
        reg_read_i <= 1'b1;
        reg_addr_i <= a;
        tick(1);
        reg_read_i <= 1'b0;
        tick(1);
        d = reg_rdata_o;
    endtask
    task automatic wait_restart();
        int k;
        for (k = 0; k < 60 && fetch_restart_o !== 1'b1; k++) tick(1);
        `CHK("restart", 1'b1, fetch_restart_o)
        `CHK("vector", 16'h0000, restart_vector_o)
        tick(1);
    endtask
    task automatic t_power_on();
        power_on_i <= 1'b1;
        tick(6);
        `CHK("pin drive", 2'b10, {reset_pin_oe_o, reset_pin_o})
        power_on_i <= 1'b0;
        wait_restart();
        `CHK("por flag", 1'b1, power_on_flag_o)
        `CHK("osc select", 1'b1, int_osc_select_o)
        `CHK("watchdog", 5'h1C, {watchdog_enable_o, watchdog_divide_o})
        $display("test power_on done");
    endtask
    task automatic t_flags();
        wr(8'h86, 8'hFF);
        `CHK("unmapped mode", 2'b00, mode_o)
        rd(8'h87);
        `CHK("reset value", PMR_POWER_CONTROL_RESET, d)
        wr(8'h87, 8'hFC);
        rd(8'h87);
        `CHK("flags", 8'hFC, d)
        rd(8'h86);
        `CHK("unmapped read", 8'h00, d)
        $display("test flags done");
    endtask
    task automatic t_idle();
        wr(8'h87, 8'hA5);
        `CHK("before done", 2'b00, mode_o)
        // The mode output trails the clock enables by one edge.
        tick(2);
        `CHK("idle mode", 2'b01, mode_o)
        `CHK("idle clocks", 3'b011, {cpu_clock_en_o, periph_clock_en_o, int_osc_en_o})
        rd(8'h87);
        `CHK("idle read", 8'hA4, d)
        irq_pending_i <= 1'b1;
        tick(3);
        `CHK("wake", 3'b001, {mode_o, cpu_clock_en_o})
        irq_pending_i <= 1'b0;
        tick(1);
        $display("test idle done");
    endtask
    // Sources 0 to 3 are the watchdog, the external pin, software and the supply monitor.
    task automatic t_idle_reset(int src);
        int k;
        wr(8'h87, 8'h01);
        tick(2);
        `CHK("idle again", 2'b01, mode_o)
        watchdog_expired_i <= (src == 0);
        ext_reset_n_i <= (src != 1);
        software_reset_i <= (src == 2);
        supply_low_i <= (src == 3);
        tick(3);
        watchdog_expired_i <= 1'b0;
        ext_reset_n_i <= 1'b1;
        software_reset_i <= 1'b0;
        supply_low_i <= 1'b0;
        for (k = 0; k < 20 && core_reset_o !== 1'b1; k++) tick(1);
        `CHK("in reset", 2'b11, {core_reset_o, stack_reinit_o})
        `CHK("disables", 2'b11, {irq_disable_o, timers_disable_o})
        `CHK("ports", 10'h3FF, {port_latch_o, weak_pullup_en_o, port_open_drain_o})
        `CHK("pin drive", (src == 3), reset_pin_oe_o)
        wait_restart();
        `CHK("run after", 3'b001, {mode_o, cpu_clock_en_o})
        `CHK("por clear", 1'b0, power_on_flag_o)
        $display("test idle_reset done");
    endtask
    task automatic t_stop();
        int k;
        missing_clock_enable_i <= 1'b1;
        wr(8'h87, 8'h03);
        tick(2);
        `CHK("stop mode", 2'b10, mode_o)
        `CHK("stop clocks", 3'b000, {cpu_clock_en_o, periph_clock_en_o, int_osc_en_o})
        irq_pending_i <= 1'b1;
        tick(4);
        `CHK("irq ignored", 3'b100, {mode_o, core_reset_o})
        irq_pending_i <= 1'b0;
        for (k = 0; k < 80 && core_reset_o !== 1'b1; k++) tick(1);
        `CHK("watch reset", 1'b1, core_reset_o)
        missing_clock_enable_i <= 1'b0;
        wait_restart();
        `CHK("stop exit", 2'b00, mode_o)
        rd(8'h87);
        `CHK("sfr reset", 8'h00, d)
        $display("test stop done");
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Main sequence.
    initial
    begin
        tick(12);
        rst_i <= 1'b0;
        wait_restart();
        t_power_on();
        t_flags();
        t_idle();
        for (int s = 0; s < 4; s++) t_idle_reset(s);
        t_stop();
        final_report();
    end
    // The tests need under a thousand cycles; five thousand means a hang.
    initial
    begin
        #500000;
        err_total++;
        final_report();
    end
endmodule
bind pmr_power_reset pmr_power_reset_sva chk_u (.clock_i, .rst_i, .reg_write_i, .reg_read_i,
    .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .instr_done_i, .irq_pending_i, .power_on_i,
    .watchdog_expired_i, .cpu_clock_en_o, .periph_clock_en_o, .int_osc_en_o, .core_reset_o,
    .fetch_restart_o, .irq_disable_o, .timers_disable_o, .port_latch_o, .reset_pin_o,
    .reset_pin_oe_o, .watchdog_divide_o, .mode_o);
